/* File: hpv_output_volume_ctrl.sv */
// Register bank for the first headphone pair volumes, the common-mode feedback
// enables and the second right output polarity and mute controls.
// Assumes write and read strobes synchronous to core_clk and a zero-cross pulse
// per first-pair channel from the analogue side.
// Assumes the analogue side takes the gain, mute and feedback outputs as levels.
// Unmapped addresses are ignored on write and read back as zero.
`timescale 1ns/10ps

module hpv_output_volume_ctrl (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [hpv_pkg::ADDR_W-1:0] regAddr,
  input wire logic [hpv_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [hpv_pkg::DATA_W-1:0] regRdData,
  input wire logic firstLeftZeroCross,
  input wire logic firstRightZeroCross,
  output logic [hpv_pkg::GAIN_W-1:0] firstLeftGainCode,
  output logic [hpv_pkg::GAIN_W-1:0] firstRightGainCode,
  output logic firstLeftSilence,
  output logic firstRightSilence,
  output logic firstPairCmFeedbackEn,
  output logic secondPairCmFeedbackEn,
  output logic secondRightInvertEn,
  output logic secondRightInvertBypass,
  output logic secondRightSilence
);

  // Pending codes hold what software wrote last; applied codes are what the amplifiers see.
  // An armed channel has seen a commit and still waits to apply its pending code.
  typedef struct packed {
    // Output control.
    logic fb1;
    logic fb2;
    // First left channel.
    logic lSilence;
    logic lZcGate;
    logic [5:0] lPending;
    logic [5:0] lApplied;
    logic lArmed;
    // First right channel.
    logic rSilence;
    logic rZcGate;
    logic [5:0] rPending;
    logic [5:0] rApplied;
    logic rArmed;
    // Second right output.
    logic r2Silence;
    logic r2Invert;
    logic r2Bypass;
    // Registered read word.
    logic [15:0] rdData;
  } hpv_state_t;

  hpv_state_t state_ff;
  hpv_state_t nxt_state;

  // Builds the readback word of a first-pair volume register; the commit bit reads 0.
  function automatic logic [15:0] hpv_vol_word(input logic silence, input logic zc, input logic [5:0] gain);
    logic [15:0] w;
    w = 16'h0000;
    w[hpv_pkg::SILENCE_BIT] = silence;
    w[hpv_pkg::ZERO_CROSS_GATE_BIT] = zc;
    w[hpv_pkg::GAIN_MSB:hpv_pkg::GAIN_LSB] = gain;
    return w;
  endfunction : hpv_vol_word

  // Flags a strobe aimed at one register address.
  function automatic logic hpv_addr_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] target);
    return strobe && (addr == target);
  endfunction : hpv_addr_hit

  // Builds the readback word of the output control register.
  function automatic logic [15:0] hpv_ctl_word(input logic fb1, input logic fb2);
    logic [15:0] w;
    w = 16'h0000;
    w[hpv_pkg::FIRST_PAIR_CM_FEEDBACK_EN_BIT] = fb1;
    w[hpv_pkg::SECOND_PAIR_CM_FEEDBACK_EN_BIT] = fb2;
    return w;
  endfunction : hpv_ctl_word

  // Builds the readback word of the second right output register.
  function automatic logic [15:0] hpv_r2_word(input logic silence, input logic inv, input logic bypass);
    logic [15:0] w;
    w = 16'h0000;
    w[hpv_pkg::SILENCE_BIT] = silence;
    w[hpv_pkg::SECOND_RIGHT_INVERT_EN_BIT] = inv;
    w[hpv_pkg::SECOND_RIGHT_INVERT_BYPASS_BIT] = bypass;
    return w;
  endfunction : hpv_r2_word

  logic wrCtl;
  logic wrLeft;
  logic wrRight;
  logic wrR2;
  logic commit;

  always_comb begin
    // Each high cycle of the write strobe is one write to the addressed register.
    wrCtl = hpv_addr_hit(regWrEn, regAddr, hpv_pkg::OUTPUT_CONTROL_ADDR);
    wrLeft = hpv_addr_hit(regWrEn, regAddr, hpv_pkg::HP1_LEFT_VOLUME_ADDR);
    wrRight = hpv_addr_hit(regWrEn, regAddr, hpv_pkg::HP1_RIGHT_VOLUME_ADDR);
    wrR2 = hpv_addr_hit(regWrEn, regAddr, hpv_pkg::HP2_RIGHT_VOLUME_ADDR);
    // Either first-pair register carries the shared commit strobe.
    commit = (wrLeft || wrRight) && regWrData[hpv_pkg::VOLUME_COMMIT_BIT];

    nxt_state = state_ff;

    // The feedback enables take effect at once; they have no commit stage.
    if (wrCtl) begin
      nxt_state.fb1 = regWrData[hpv_pkg::FIRST_PAIR_CM_FEEDBACK_EN_BIT];
      nxt_state.fb2 = regWrData[hpv_pkg::SECOND_PAIR_CM_FEEDBACK_EN_BIT];
    end

    if (wrLeft) begin
      nxt_state.lSilence = regWrData[hpv_pkg::SILENCE_BIT];
      nxt_state.lZcGate = regWrData[hpv_pkg::ZERO_CROSS_GATE_BIT];
      nxt_state.lPending = regWrData[hpv_pkg::GAIN_MSB:hpv_pkg::GAIN_LSB];
    end
    if (wrRight) begin
      nxt_state.rSilence = regWrData[hpv_pkg::SILENCE_BIT];
      nxt_state.rZcGate = regWrData[hpv_pkg::ZERO_CROSS_GATE_BIT];
      nxt_state.rPending = regWrData[hpv_pkg::GAIN_MSB:hpv_pkg::GAIN_LSB];
    end

    // A commit arms both channels; an armed channel applies at once or waits for its zero cross.
    // The checks read nxt_state so that the code and gate bit of the commit write itself apply.
    // A later commit while armed simply re-arms with the latest pending code.
    if (commit) begin
      nxt_state.lArmed = 1'b1;
      nxt_state.rArmed = 1'b1;
    end
    if (nxt_state.lArmed && (!nxt_state.lZcGate || firstLeftZeroCross)) begin
      nxt_state.lApplied = nxt_state.lPending;
      nxt_state.lArmed = 1'b0;
    end
    if (nxt_state.rArmed && (!nxt_state.rZcGate || firstRightZeroCross)) begin
      nxt_state.rApplied = nxt_state.rPending;
      nxt_state.rArmed = 1'b0;
    end

    // The second right controls have no commit stage.
    if (wrR2) begin
      nxt_state.r2Silence = regWrData[hpv_pkg::SILENCE_BIT];
      nxt_state.r2Invert = regWrData[hpv_pkg::SECOND_RIGHT_INVERT_EN_BIT];
      nxt_state.r2Bypass = regWrData[hpv_pkg::SECOND_RIGHT_INVERT_BYPASS_BIT];
    end

    // The read word comes from state_ff, so a read in the cycle of a write returns the old contents.
    // Volume reads show the pending code, which may not have reached the amplifier yet.
    if (regRdEn) begin
      case (regAddr)
        hpv_pkg::OUTPUT_CONTROL_ADDR: begin
          nxt_state.rdData = hpv_ctl_word(state_ff.fb1, state_ff.fb2);
        end
        hpv_pkg::HP1_LEFT_VOLUME_ADDR: begin
          nxt_state.rdData = hpv_vol_word(state_ff.lSilence, state_ff.lZcGate, state_ff.lPending);
        end
        hpv_pkg::HP1_RIGHT_VOLUME_ADDR: begin
          nxt_state.rdData = hpv_vol_word(state_ff.rSilence, state_ff.rZcGate, state_ff.rPending);
        end
        hpv_pkg::HP2_RIGHT_VOLUME_ADDR: begin
          nxt_state.rdData = hpv_r2_word(state_ff.r2Silence, state_ff.r2Invert, state_ff.r2Bypass);
        end
        default: begin
          nxt_state.rdData = 16'h0000;
        end
      endcase
    end
  end

  // Reset loads the power-on field values; nothing stays armed across it.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_ff.fb1 <= hpv_pkg::RST_FEEDBACK_EN;
      state_ff.fb2 <= hpv_pkg::RST_FEEDBACK_EN;
      state_ff.lSilence <= hpv_pkg::RST_SILENCE;
      state_ff.lZcGate <= hpv_pkg::RST_ZERO_CROSS_GATE;
      state_ff.lPending <= hpv_pkg::RST_GAIN_CODE;
      state_ff.lApplied <= hpv_pkg::RST_GAIN_CODE;
      state_ff.lArmed <= 1'b0;
      state_ff.rSilence <= hpv_pkg::RST_SILENCE;
      state_ff.rZcGate <= hpv_pkg::RST_ZERO_CROSS_GATE;
      state_ff.rPending <= hpv_pkg::RST_GAIN_CODE;
      state_ff.rApplied <= hpv_pkg::RST_GAIN_CODE;
      state_ff.rArmed <= 1'b0;
      state_ff.r2Silence <= hpv_pkg::RST_SILENCE;
      state_ff.r2Invert <= hpv_pkg::RST_INVERT_EN;
      state_ff.r2Bypass <= hpv_pkg::RST_INVERT_BYPASS;
      state_ff.rdData <= hpv_pkg::RST_READ_DATA;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Software keeps the invert pair consistent; the mute gates the output in either polarity.
  // Every output is a plain copy of a state flip-flop.
  always_comb begin
    regRdData = state_ff.rdData;
    firstLeftGainCode = state_ff.lApplied;
    firstRightGainCode = state_ff.rApplied;
    firstLeftSilence = state_ff.lSilence;
    firstRightSilence = state_ff.rSilence;
    firstPairCmFeedbackEn = state_ff.fb1;
    secondPairCmFeedbackEn = state_ff.fb2;
    secondRightInvertEn = state_ff.r2Invert;
    secondRightInvertBypass = state_ff.r2Bypass;
    secondRightSilence = state_ff.r2Silence;
  end

endmodule : hpv_output_volume_ctrl

/* File: hpv_pkg.sv */
// Package for the first headphone pair volume and output control register bank.
// Assumes a 16-bit control interface with 8-bit register addresses.
package hpv_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int GAIN_W = 6;

  // Register addresses.
  localparam logic [7:0] OUTPUT_CONTROL_ADDR = 8'h4c;
  localparam logic [7:0] HP1_LEFT_VOLUME_ADDR = 8'h68;
  localparam logic [7:0] HP1_RIGHT_VOLUME_ADDR = 8'h69;
  localparam logic [7:0] HP2_RIGHT_VOLUME_ADDR = 8'h6b;

  // Output control fields.
  localparam int FIRST_PAIR_CM_FEEDBACK_EN_BIT = 0;
  localparam int SECOND_PAIR_CM_FEEDBACK_EN_BIT = 2;

  // Volume register fields.
  localparam int SILENCE_BIT = 14;
  localparam int ZERO_CROSS_GATE_BIT = 13;
  localparam int SECOND_RIGHT_INVERT_EN_BIT = 10;
  localparam int SECOND_RIGHT_INVERT_BYPASS_BIT = 9;
  localparam int VOLUME_COMMIT_BIT = 8;
  localparam int GAIN_LSB = 2;
  localparam int GAIN_MSB = 7;

  // Reset values.
  localparam logic RST_FEEDBACK_EN = 1'b0;
  localparam logic RST_SILENCE = 1'b0;
  localparam logic RST_ZERO_CROSS_GATE = 1'b0;
  localparam logic [5:0] RST_GAIN_CODE = 6'h39;
  localparam logic RST_INVERT_EN = 1'b0;
  localparam logic RST_INVERT_BYPASS = 1'b1;
  localparam logic [15:0] RST_READ_DATA = 16'h0000;

endpackage : hpv_pkg

/* File: hpv_output_volume_ctrl_props.sv */
// Assertions for the headphone output volume register bank.
// Bound to the top module and sees only its ports.
`timescale 1ns/10ps
module hpv_output_volume_ctrl_props (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [15:0] regRdData,
  input wire logic firstLeftZeroCross,
  input wire logic firstRightZeroCross,
  input wire logic [5:0] firstLeftGainCode,
  input wire logic [5:0] firstRightGainCode,
  input wire logic firstLeftSilence,
  input wire logic firstRightSilence,
  input wire logic firstPairCmFeedbackEn,
  input wire logic secondPairCmFeedbackEn,
  input wire logic secondRightInvertEn,
  input wire logic secondRightInvertBypass,
  input wire logic secondRightSilence
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire wrLeft = regWrEn && regAddr == 8'h68;
  wire wrRight = regWrEn && regAddr == 8'h69;
  // Shadow of the left channel's commit state, rebuilt from the bus and the left zero-cross input.
  logic leftZcShadow_ff;
  logic leftWait_ff;
  logic [5:0] leftPend_ff;
  logic nxt_leftZcShadow;
  logic nxt_leftWait;
  logic [5:0] nxt_leftPend;
  always_comb begin
    nxt_leftZcShadow = wrLeft ? regWrData[13] : leftZcShadow_ff;
    nxt_leftPend = wrLeft ? regWrData[7:2] : leftPend_ff;
    nxt_leftWait = leftWait_ff || ((wrLeft || wrRight) && regWrData[8]);
    if (nxt_leftWait && (!nxt_leftZcShadow || firstLeftZeroCross)) begin
      nxt_leftWait = 1'b0;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      leftZcShadow_ff <= 1'b0;
      leftWait_ff <= 1'b0;
      leftPend_ff <= 6'h39;
    end else begin
      leftZcShadow_ff <= nxt_leftZcShadow;
      leftWait_ff <= nxt_leftWait;
      leftPend_ff <= nxt_leftPend;
    end
  end
  property p_silence; wrLeft |=> firstLeftSilence == $past(regWrData[14]); endproperty
  a_silence: assert property (p_silence) else $error("left mute");
  property p_commit; regWrEn && regAddr == 8'h69 && regWrData[13:8] == 6'h01 |=>
    firstRightGainCode == $past(regWrData[7:2]); endproperty
  a_commit: assert property (p_commit) else $error("commit");
  property p_pend; wrLeft && !regWrData[8] && !leftWait_ff |=> $stable(firstLeftGainCode); endproperty
  a_pend: assert property (p_pend) else $error("pending");
  property p_zcapply; leftWait_ff && leftZcShadow_ff && !regWrEn && firstLeftZeroCross |=>
    firstLeftGainCode == $past(leftPend_ff); endproperty
  a_zcapply: assert property (p_zcapply) else $error("zero cross apply");
  property p_rsilence; wrRight |=> firstRightSilence == $past(regWrData[14]); endproperty
  a_rsilence: assert property (p_rsilence) else $error("right mute");
  property p_zcgate; !regWrEn && !firstLeftZeroCross |=> $stable(firstLeftGainCode); endproperty
  a_zcgate: assert property (p_zcgate) else $error("zero cross");
  property p_fb; regWrEn && regAddr == 8'h4c |=> {secondPairCmFeedbackEn, firstPairCmFeedbackEn} ==
    {$past(regWrData[2]), $past(regWrData[0])}; endproperty
  a_fb: assert property (p_fb) else $error("feedback");
  property p_sec; regWrEn && regAddr == 8'h6b |=> {secondRightSilence, secondRightInvertEn,
    secondRightInvertBypass} == {$past(regWrData[14]), $past(regWrData[10:9])}; endproperty
  a_sec: assert property (p_sec) else $error("second right");
  property p_read; wrLeft ##1 (regRdEn && regAddr == 8'h68 && !regWrEn) |=> regRdData ==
    {1'b0, $past(regWrData[14:13], 2), 5'h00, $past(regWrData[7:2], 2), 2'h0}; endproperty
  a_read: assert property (p_read) else $error("readback");
  property p_rst; $rose(rstn) |-> firstLeftGainCode == 6'h39 && firstRightGainCode == 6'h39 &&
    secondRightInvertBypass && !secondRightInvertEn; endproperty
  a_rst: assert property (p_rst) else $error("reset");
endmodule : hpv_output_volume_ctrl_props
bind hpv_output_volume_ctrl hpv_output_volume_ctrl_props hpv_output_volume_ctrl_props_i (.*);

/* File: tb_hpv_output_volume_ctrl.sv */
// Testbench for the headphone output volume register bank.
// Drives the register strobes itself at the falling clock edge.
`timescale 1ns/10ps
module tb_hpv_output_volume_ctrl;
  logic core_clk = 0, rstn = 0, regWrEn = 0, regRdEn = 0, leftZc = 0, rightZc = 0;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWrData = 16'h0000, regRdData;
  logic [5:0] lGain, rGain;
  logic lSil, rSil, fb1, fb2, inv, byp, sil2;
  int n_fail = 0, total_checks = 0;
  hpv_output_volume_ctrl hpv_output_volume_ctrl_i (.core_clk(core_clk), .rstn(rstn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .firstLeftZeroCross(leftZc), .firstRightZeroCross(rightZc), .firstLeftGainCode(lGain),
    .firstRightGainCode(rGain), .firstLeftSilence(lSil), .firstRightSilence(rSil),
    .firstPairCmFeedbackEn(fb1), .secondPairCmFeedbackEn(fb2), .secondRightInvertEn(inv),
    .secondRightInvertBypass(byp), .secondRightSilence(sil2));
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic gains(input logic [15:0] e);
    chk("gains", e, {2'h0, lGain, 2'h0, rGain});
  endtask : gains
  task automatic flags(input logic [15:0] e);
    chk("flags", e, {9'h000, lSil, rSil, fb1, fb2, inv, byp, sil2});
  endtask : flags
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge core_clk);
    regWrEn = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge core_clk);
    regRdEn = 1'b0;
    chk("read", e, regRdData);
  endtask : rd
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (1000) @(posedge core_clk);
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    rstn = 1'b1;
    gains(16'h3939);
    flags(16'h0002);
    rd(8'h68, 16'h00e4);
    rd(8'h6b, 16'h0200);
    wr(8'h68, 16'h0004);
    gains(16'h3939);
    rd(8'h68, 16'h0004);
    wr(8'h69, 16'h0108);
    gains(16'h0102);
    wr(8'h68, 16'h4000);
    rd(8'h68, 16'h4000);
    flags(16'h0042);
    wr(8'h68, 16'h20fc);
    wr(8'h68, 16'h21fc);
    repeat (3) @(negedge core_clk);
    gains(16'h0102);
    rd(8'h68, 16'h20fc);
    leftZc = 1'b1;
    @(negedge core_clk);
    leftZc = 1'b0;
    gains(16'h3f02);
    wr(8'h4c, 16'h0005);
    rd(8'h4c, 16'h0005);
    wr(8'h6b, 16'h4400);
    flags(16'h001d);
    wr(8'h50, 16'hffff);
    rd(8'h50, 16'h0000);
    wr(8'h6b, 16'h0200);
    flags(16'h001a);
    wr(8'h69, 16'h61f0);
    flags(16'h003a);
    rd(8'h69, 16'h60f0);
    gains(16'h3f02);
    rightZc = 1'b1;
    @(negedge core_clk);
    rightZc = 1'b0;
    gains(16'h3f3c);
    wr(8'h6b, 16'h4200);
    flags(16'h003b);
    rstn = 1'b0;
    @(negedge core_clk);
    rstn = 1'b1;
    flags(16'h0002);
    gains(16'h3939);
    complete_run();
  end
endmodule : tb_hpv_output_volume_ctrl
